// file: hdl/rzsm_in_if.sv
// Carries the synchronised field, stop and reset levels to the sequence logic.
// Assumes both ends run on the system clock.
`timescale 1ns/100ps
`default_nettype none

interface rzsm_in_if;
	logic prot_infr;
	logic warn_infr;
	logic estop_ok;
	logic reset_btn;
	logic scanner_ok;

	modport drv (output prot_infr, output warn_infr, output estop_ok,
	             output reset_btn, output scanner_ok);
	modport mon (input prot_infr, input warn_infr, input estop_ok,
	             input reset_btn, input scanner_ok);
endinterface

`default_nettype wire

// file: hdl/rzsm_in_sync.sv
// Two-stage synchroniser for all pin inputs of the sequence monitor.
// Assumes raw inputs are asynchronous to clk_i.
`timescale 1ns/100ps
`default_nettype none

module rzsm_in_sync
	import rzsm_pkg::*;
(
	// Clock and reset
	input  wire logic            clk_i,
	input  wire logic            rst_n_i,
	// Raw pins
	input  wire logic [IN_W-1:0] raw_i,
	// Synchronised levels
	rzsm_in_if.drv               sync
);

	// Reset value is zero for each input, so the ok levels read unhealthy and both fields read clear.
	logic [IN_W-1:0] meta_q;
	logic [IN_W-1:0] stab_q;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			meta_q <= '0;
			stab_q <= '0;
		end else begin
			meta_q <= raw_i;
			stab_q <= meta_q;
		end
	end

	assign sync.prot_infr  = stab_q[IN_PROT];
	assign sync.warn_infr  = stab_q[IN_WARN];
	assign sync.estop_ok   = stab_q[IN_ESTOP_OK];
	assign sync.reset_btn  = stab_q[IN_RESET];
	assign sync.scanner_ok = stab_q[IN_SCAN_OK];

endmodule // rzsm_in_sync

`default_nettype wire

// file: hdl/rzsm_monitor.sv
// Robot zone sequence monitor: stops, speed request and field set selection.
// Assumes one 40 MHz clock, pins asynchronous to it, and a robot controller
// that treats a low stop output as a stop demand.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Release needs protective clear, then 500 ms warning.
// - Reduced speed still requested after steps one, two.
// - After dwell, release protective stop, keep reduced.
// - Release allows restart only at reduced speed.
// - Warning clears after valid exit: select set one.
// - Full speed only with both fields clear.
// - Short warning dwell trips fence stop, category one.
// - Protective clear without warning blocks restart.
// - Release decision rests on protective field, sequence state and health.
// - Protective infringement commands protective stop immediately.
// - Protective stop held while protective field infringed.
// - Emergency stop forces estop, protective and speed outputs to stop, always.
// - Emergency stop latched until manual reset.
// - Reset accepted only with both fields clear.
// - After power-up stay stopped until valid reset.
// - Internal fault keeps all outputs stopped.
// - Only a valid reset sequence lifts an emergency stop or a fence trip stop.
// - Restart needs every safety input healthy.
// - Field set one selected after reset.
// - Warning infringement requests reduced speed.
// - Accepted manual reset drives emergency stop output high.
// - Protective stop clears itself once conditions allow.
module rzsm_monitor
	import rzsm_pkg::*;
#(
	parameter int unsigned DWELL_CYC = DWELL_CYCLES,
	parameter int unsigned RST_HOLD  = RST_HOLD_DEF
)(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	// Scanner outputs: field levels high while infringed, scanner_ok_i high while healthy
	input  wire logic       prot_infr_i,
	input  wire logic       warn_infr_i,
	input  wire logic       scanner_ok_i,
	// Operator devices
	input  wire logic       estop_ok_i,
	input  wire logic       reset_btn_i,
	// Robot controller safety inputs, low means stop or request
	output var  logic       estop_n_o,
	output var  logic       prot_stop_n_o,
	output var  logic       speed_red_n_o,
	output var  logic       fence_trip_stop_n_o,
	// Scanner field set select, high selects set two
	output var  logic       field_set2_o,
	// Status
	output var  logic [2:0] seq_state_o,
	output var  logic       restart_locked_o,
	output var  logic       fault_o
);

	localparam int unsigned CW = (DWELL_CYC > 1) ? $clog2(DWELL_CYC) : 1;
	localparam int unsigned HW = $clog2(RST_HOLD + 1);
	localparam logic [CW-1:0] DWELL_LAST = CW'(DWELL_CYC - 1);
	localparam logic [HW-1:0] HOLD_MIN   = HW'(RST_HOLD);

	// Refused at elaboration: a zero dwell or hold would release without any wait.
	if (DWELL_CYC < 1 || RST_HOLD < 1) begin : g_bad_params
		$error("rzsm_monitor: DWELL_CYC and RST_HOLD must be at least one");
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// Input synchronisation.

	rzsm_in_if in_s ();

	rzsm_in_sync u_sync (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.raw_i   ({scanner_ok_i, reset_btn_i, estop_ok_i, warn_infr_i, prot_infr_i}),
		.sync    (in_s)
	);

	logic prot;
	logic warn;
	logic estop_ok;
	logic scan_ok;
	assign prot     = in_s.prot_infr;
	assign warn     = in_s.warn_infr;
	assign estop_ok = in_s.estop_ok;
	assign scan_ok  = in_s.scanner_ok;

	////////////////////////////////////////////////////////////////////////////////////////////
	// Decoding helpers.

	// States in which the sequence layer lets the protective stop go.
	function automatic logic seq_released(input rzsm_seq_e s);
		return (s == RZSM_ST_CLEAR) || (s == RZSM_ST_RELEASE);
	endfunction

	function automatic logic seq_legal(input rzsm_seq_e s);
		return (s == RZSM_ST_HOLD) || (s == RZSM_ST_CLEAR) || (s == RZSM_ST_PROT) ||
		       (s == RZSM_ST_DWELL) || (s == RZSM_ST_RELEASE) || (s == RZSM_ST_TRIP);
	endfunction

	////////////////////////////////////////////////////////////////////////////////////////////
	// Reset pushbutton: a press must last RST_HOLD cycles and counts on release.
	// Taking the release, not the press, keeps a stuck or shorted button from resetting.

	logic          btn_q;
	logic [HW-1:0] hold_q;
	logic          rst_pulse;
	logic          rst_ok;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			btn_q <= 1'h0;
		end else begin
			btn_q <= in_s.reset_btn;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			hold_q <= '0;
		end else if (!in_s.reset_btn) begin
			hold_q <= '0;
		end else if (hold_q != HOLD_MIN) begin
			hold_q <= hold_q + HW'(1);
		end
	end

	assign rst_pulse = btn_q && !in_s.reset_btn && (hold_q == HOLD_MIN);
	assign rst_ok    = rst_pulse && !prot && !warn && estop_ok && scan_ok;

	////////////////////////////////////////////////////////////////////////////////////////////
	// Exit sequence state machine.

	rzsm_seq_e state_q;
	rzsm_seq_e state_d;
	logic      dwell_done;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			RZSM_ST_HOLD: begin
				if (rst_ok) begin
					state_d = RZSM_ST_CLEAR;
				end
			end
			RZSM_ST_CLEAR: begin
				if (prot) begin
					state_d = RZSM_ST_PROT;
				end
			end
			RZSM_ST_PROT: begin
				if (!prot) begin
					state_d = warn ? RZSM_ST_DWELL : RZSM_ST_TRIP;
				end
			end
			RZSM_ST_DWELL: begin
				if (prot) begin
					state_d = RZSM_ST_PROT;
				end else if (!warn) begin
					state_d = RZSM_ST_TRIP;
				end else if (dwell_done) begin
					state_d = RZSM_ST_RELEASE;
				end
			end
			RZSM_ST_RELEASE: begin
				if (prot) begin
					state_d = RZSM_ST_PROT;
				end else if (!warn) begin
					state_d = RZSM_ST_CLEAR;
				end
			end
			RZSM_ST_TRIP: begin
				if (rst_ok) begin
					state_d = RZSM_ST_CLEAR;
				end
			end
			default: begin
				state_d = RZSM_ST_TRIP;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_q <= RZSM_ST_HOLD;
		end else begin
			state_q <= state_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// Warning dwell counter.

	logic [CW-1:0] dwell_q;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			dwell_q <= '0;
		end else if (state_q != RZSM_ST_DWELL || !warn || prot) begin
			dwell_q <= '0;
		end else if (dwell_q != DWELL_LAST) begin
			dwell_q <= dwell_q + CW'(1);
		end
	end

	assign dwell_done = (dwell_q == DWELL_LAST);

	////////////////////////////////////////////////////////////////////////////////////////////
	// Emergency stop latch and internal fault latch.
	// In both latches the set wins over an accepted reset in the same cycle.

	logic estop_lock_q;
	logic fault_q;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			estop_lock_q <= 1'h1;
		end else if (!estop_ok) begin
			estop_lock_q <= 1'h1;
		end else if (rst_ok) begin
			estop_lock_q <= 1'h0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			fault_q <= 1'h0;
		end else if (!seq_legal(state_q)) begin
			fault_q <= 1'h1;
		end else if (rst_ok) begin
			fault_q <= 1'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// Field set selection. The approach delay before set two is not modelled here;
	// the scanner switches as soon as the warning field is seen.

	logic fset_q;
	logic fset_d;

	always_comb begin
		if (warn) begin
			fset_d = FSET_2;
		end else if (state_d == RZSM_ST_DWELL || state_d == RZSM_ST_PROT) begin
			fset_d = fset_q;
		end else begin
			fset_d = FSET_1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			fset_q <= FSET_1;
		end else begin
			fset_q <= fset_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// Registered outputs. Every stop output except fence_trip_stop_n_o is low during reset.

	logic healthy;
	assign healthy = estop_ok && scan_ok && !fault_q;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			estop_n_o <= LVL_STOP;
		end else begin
			estop_n_o <= (estop_ok && !estop_lock_q && !fault_q) ? LVL_RUN : LVL_STOP;
		end
	end

	// The release depends on the protective field, the sequence state and health (estop, scanner, fault).
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			prot_stop_n_o <= LVL_STOP;
		end else if (prot || !healthy) begin
			prot_stop_n_o <= LVL_STOP;
		end else begin
			prot_stop_n_o <= seq_released(state_q) ? LVL_RUN : LVL_STOP;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			speed_red_n_o <= LVL_STOP;
		end else if (warn || prot || state_q != RZSM_ST_CLEAR || !healthy) begin
			speed_red_n_o <= LVL_STOP;
		end else begin
			speed_red_n_o <= LVL_RUN;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			fence_trip_stop_n_o <= LVL_RUN;
		end else begin
			fence_trip_stop_n_o <= (state_q == RZSM_ST_TRIP) ? LVL_STOP : LVL_RUN;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			field_set2_o     <= FSET_1;
			seq_state_o      <= RZSM_ST_HOLD;
			restart_locked_o <= 1'h1;
			fault_o          <= 1'h0;
		end else begin
			field_set2_o     <= fset_q;
			seq_state_o      <= state_q;
			restart_locked_o <= !seq_released(state_q) || estop_lock_q || !healthy;
			fault_o          <= fault_q;
		end
	end

endmodule // rzsm_monitor

`default_nettype wire

// file: hdl/rzsm_pkg.sv
// Shared constants and types for the robot zone sequence monitor.
// Assumes a single 40 MHz system clock and a synchronous active-low reset.
`default_nettype none

package rzsm_pkg;

	////////////////////////////////////////////////////////////////////////////////////////////
	// Timing.
	localparam int unsigned CLK_HZ       = 40_000_000;
	localparam int unsigned MS_PER_S     = 1000;
	localparam int unsigned DWELL_MS     = 500;
	localparam int unsigned DWELL_CYCLES = DWELL_MS * (CLK_HZ / MS_PER_S);
	localparam int unsigned SYNC_STAGES  = 2;
	localparam int unsigned RST_HOLD_DEF = 4;

	////////////////////////////////////////////////////////////////////////////////////////////
	// Input bundle layout.
	localparam int unsigned IN_W        = 5;
	localparam int unsigned IN_PROT     = 0;
	localparam int unsigned IN_WARN     = 1;
	localparam int unsigned IN_ESTOP_OK = 2;
	localparam int unsigned IN_RESET    = 3;
	localparam int unsigned IN_SCAN_OK  = 4;

	////////////////////////////////////////////////////////////////////////////////////////////
	// Output levels and reset values.
	localparam logic LVL_STOP = 1'h0;
	localparam logic LVL_RUN  = 1'h1;
	localparam logic FSET_1   = 1'h0;
	localparam logic FSET_2   = 1'h1;

	////////////////////////////////////////////////////////////////////////////////////////////
	// Exit sequence states.
	typedef enum logic [2:0] {
		RZSM_ST_HOLD    = 3'h0,
		RZSM_ST_CLEAR   = 3'h1,
		RZSM_ST_PROT    = 3'h2,
		RZSM_ST_DWELL   = 3'h3,
		RZSM_ST_RELEASE = 3'h4,
		RZSM_ST_TRIP    = 3'h5
	} rzsm_seq_e;

endpackage

`default_nettype wire

// file: tb/rzsm_monitor_assertions.sv
// Port checker for the zone sequence monitor.
// Assumes it is bound to every rzsm_monitor instance.
`timescale 1ns/100ps
`default_nettype none
module rzsm_monitor_assertions (
	// Watched ports
	input wire logic       clk_i,
	input wire logic       rst_n_i,
	input wire logic       prot_infr_i,
	input wire logic       warn_infr_i,
	input wire logic       scanner_ok_i,
	input wire logic       estop_ok_i,
	input wire logic       reset_btn_i,
	input wire logic       estop_n_o,
	input wire logic       prot_stop_n_o,
	input wire logic       speed_red_n_o,
	input wire logic       fence_trip_stop_n_o,
	input wire logic       field_set2_o,
	input wire logic [2:0] seq_state_o,
	input wire logic       restart_locked_o,
	input wire logic       fault_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// Four samples cover two sync stages and the output register.
	a_prot_stop_now: assert property (prot_infr_i[*4] |-> !prot_stop_n_o)
		else $error("protective stop missing");
	a_estop_first: assert property (!estop_ok_i[*4] |-> !estop_n_o && !prot_stop_n_o
		&& !speed_red_n_o) else $error("emergency stop not forced");
	a_estop_latch: assert property ($fell(estop_n_o) |=> !estop_n_o[*8])
		else $error("emergency stop released early");
	a_warn_slows: assert property (warn_infr_i[*4] |-> !speed_red_n_o)
		else $error("reduced speed not requested");
	a_release_slow: assert property ($rose(prot_stop_n_o) && $past(warn_infr_i, 3)
		|-> !speed_red_n_o) else $error("release not at reduced speed");
	a_full_speed: assert property (speed_red_n_o[*2] |-> prot_stop_n_o && !field_set2_o)
		else $error("full speed with stop or set two");
	a_trip_stops: assert property (!fence_trip_stop_n_o[*2] |-> !prot_stop_n_o
		&& !speed_red_n_o) else $error("trip without stop");
	a_fault_stops: assert property (fault_o |-> !prot_stop_n_o && !speed_red_n_o)
		else $error("fault without stop");
	a_scan_health: assert property (!scanner_ok_i[*4] |-> !prot_stop_n_o)
		else $error("unhealthy scanner released");
	a_reset_vals: assert property (disable iff (1'b0) !rst_n_i |=> !estop_n_o
		&& !prot_stop_n_o && !speed_red_n_o && fence_trip_stop_n_o && !field_set2_o
		&& restart_locked_o) else $error("bad reset values");
	c_release: cover property ($rose(prot_stop_n_o) && !speed_red_n_o);
	c_trip: cover property ($fell(fence_trip_stop_n_o));
	c_estop_on: cover property ($rose(estop_n_o));
endmodule // rzsm_monitor_assertions
bind rzsm_monitor rzsm_monitor_assertions u_rzsm_monitor_assertions (.clk_i(clk_i),
	.rst_n_i(rst_n_i), .prot_infr_i(prot_infr_i), .warn_infr_i(warn_infr_i),
	.scanner_ok_i(scanner_ok_i), .estop_ok_i(estop_ok_i), .reset_btn_i(reset_btn_i),
	.estop_n_o(estop_n_o), .prot_stop_n_o(prot_stop_n_o), .speed_red_n_o(speed_red_n_o),
	.fence_trip_stop_n_o(fence_trip_stop_n_o), .field_set2_o(field_set2_o),
	.seq_state_o(seq_state_o), .restart_locked_o(restart_locked_o), .fault_o(fault_o));
`default_nettype wire

// file: tb/rzsm_monitor_bench.sv
// Self-checking bench: a step model of the exit sequence against the design.
// Assumes a short dwell parameter so the run stays brief.
`timescale 1ns/100ps
`default_nettype none
module rzsm_monitor_bench;
	localparam int unsigned DW = 20;
	localparam int unsigned RH = 2;
	logic       clk_i   = 1'b0;
	logic       rst_n_i = 1'b0;
	logic [1:0] pos     = 2'h0;
	logic       sok     = 1'b1;
	logic       eok     = 1'b1;
	logic       rbt     = 1'b0;
	logic       prot, warn, scok, eso, pso, spo, fto, fso, lko, flo;
	logic [2:0] sto;
	int         n_fail  = 0;
	int         n_tests = 0;
	int         ms      = 0;
	int         tn      = 0;
	int         q[$];
	bit         lat     = 1'b1;
	bit         f       = 1'b0;
	always #12.5 clk_i = ~clk_i;
	rzsm_scan_model u_rzsm_scan_model (.clk_i(clk_i), .pos_i(pos), .ok_i(sok),
		.prot_o(prot), .warn_o(warn), .ok_o(scok));
	rzsm_monitor #(.DWELL_CYC(DW), .RST_HOLD(RH)) u_rzsm_monitor (.clk_i(clk_i),
		.rst_n_i(rst_n_i), .prot_infr_i(prot), .warn_infr_i(warn), .scanner_ok_i(scok),
		.estop_ok_i(eok), .reset_btn_i(rbt), .estop_n_o(eso), .prot_stop_n_o(pso),
		.speed_red_n_o(spo), .fence_trip_stop_n_o(fto), .field_set2_o(fso),
		.seq_state_o(sto), .restart_locked_o(lko), .fault_o(flo));
	////////////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic done();
		tn++;
		$display("test %0d done", tn);
	endtask
	// Moves the person, steps the model, waits n cycles, then compares.
	task automatic go(input logic [1:0] np, input int n);
		logic [8:0] e, g;
		pos <= np;
		case (ms)
			1: if (np == 2'h2) ms = 2;
			2: if (np != 2'h2) ms = (np == 2'h1) ? 3 : 5;
			3, 4: if (np == 2'h2) ms = 2;
				else if (np == 2'h0) ms = (ms == 4) ? 1 : 5;
			default: ;
		endcase
		if (ms == 3 && n > DW + 6) ms = 4;
		f = (np != 2'h0) ? 1'b1 : ((ms == 2 || ms == 3) ? f : 1'b0);
		repeat (n) @(posedge clk_i);
		@(negedge clk_i);
		// The model step number doubles as the expected state code.
		e = {!(ms == 1 || ms == 4) || lat || !eok || !sok, 3'(ms), !lat,
			np != 2'h2 && (ms == 1 || ms == 4) && eok && sok,
			np == 2'h0 && ms == 1 && eok && sok, ms != 5, f};
		g = {lko, sto, eso, pso, spo, fto, fso};
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("Error t=%0t exp=%h got=%h", $time, e, g);
		end
		@(posedge clk_i);
	endtask
	// The button counts only when released after its hold with the cell clear.
	task automatic press();
		rbt <= 1'b1;
		repeat (RH + 4) @(posedge clk_i);
		rbt <= 1'b0;
		if (pos == 2'h0 && eok && sok) begin
			lat = 1'b0;
			if (ms == 0 || ms == 5) ms = 1;
		end
		go(pos, 8);
	endtask
	////////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h2f8b_61be));
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		go(2'h0, 4);
		go(2'h2, 8);
		press();
		go(2'h0, 8);
		press();
		done();
		go(2'h1, 8);
		go(2'h2, 8);
		go(2'h1, DW + 10);
		go(2'h0, 8);
		done();
		for (int i = 0; i < 6; i++) begin
			q.push_back((($urandom % 2) != 0) ? 27 + $urandom % 8 : 6 + $urandom % 8);
		end
		foreach (q[i]) begin
			go(2'h2, 8);
			go(2'h1, q[i]);
			go(2'h0, 8);
			press();
		end
		done();
		go(2'h2, 8);
		go(2'h1, 12);
		go(2'h2, 8);
		go(2'h1, 12);
		go(2'h0, 8);
		press();
		go(2'h2, 8);
		go(2'h0, 8);
		press();
		done();
		eok <= 1'b0;
		lat = 1'b1;
		go(2'h0, 8);
		eok <= 1'b1;
		go(2'h0, 8);
		press();
		sok <= 1'b0;
		go(2'h0, 8);
		sok <= 1'b1;
		go(2'h0, 8);
		done();
		give_verdict();
	end
	initial begin
		#(25 * 20_000);
		n_fail++;
		give_verdict();
	end
endmodule // rzsm_monitor_bench
`default_nettype wire

// file: tb/rzsm_scan_model.sv
// Scanner model: turns a person position into field levels.
// Assumes the bench moves the person just after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module rzsm_scan_model (
	// Clock and position: 0 outside, 1 warning field, 2 protective field
	input  wire logic       clk_i,
	input  wire logic [1:0] pos_i,
	input  wire logic       ok_i,
	// Scanner outputs
	output var  logic       prot_o = 1'b0,
	output var  logic       warn_o = 1'b0,
	output var  logic       ok_o   = 1'b1
);
	// A person in the protective field also stands in the larger warning field.
	always @(posedge clk_i) begin
		prot_o <= (pos_i == 2'h2);
		warn_o <= (pos_i != 2'h0);
		ok_o   <= ok_i;
	end
endmodule // rzsm_scan_model
`default_nettype wire
